// file: bench/ddbl_dev_model.sv
// Behavioural model of the dual converter's input and converter latches.
`timescale 1ns/100ps
`default_nettype none
module ddbl_dev_model (
    input wire logic clk_i, // Sampling clock.
    input wire logic [7:0] data_i, // Data pins.
    input wire logic lo_n_i, // Low byte enable.
    input wire logic hi_n_i, // High byte enable.
    input wire logic cv_n_i, // Converter enable.
    input wire logic [1:0] wr_n_i, // Strobes, B in bit 1.
    input wire logic [1:0] cs_n_i, // Selects, B in bit 1.
    input wire logic zero_all_n_i, // Clear line.
    output logic [15:0] dac_a_o, // Channel A code.
    output logic [15:0] dac_b_o // Channel B code.
);
    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    logic [15:0] in_q [2];
    logic [15:0] cv_q [2];
    logic [1:0] sel_q = 2'b00;
    // Pins are sampled each cycle; an enabled byte or converter latch follows its input, while a serial load shifts in data bit 0 once per strobe.
    // The input latch's next value is worked out first, so that a byte
    // can flow straight on into the converter latch in the same cycle.
    always @(posedge clk_i) begin
        for (int c = 0; c < 2; c++) begin
            logic sel;
            logic ser;
            logic [15:0] nxt;
            sel = !wr_n_i[c] && !cs_n_i[c];
            ser = !lo_n_i && !hi_n_i;
            nxt = in_q[c];
            if (sel && ser) begin
                if (!sel_q[c]) nxt = {in_q[c][14:0], data_i[0]};
            end else if (sel) begin
                if (!hi_n_i) nxt[15:8] = data_i;
                if (!lo_n_i) nxt[7:0] = data_i;
            end
            if (!zero_all_n_i) begin
                in_q[c] <= 16'h0000;
                cv_q[c] <= 16'h0000;
            end else begin
                in_q[c] <= nxt;
                if (sel && !ser && !cv_n_i) cv_q[c] <= nxt;
            end
            sel_q[c] <= sel;
        end
    end
    // Codes leave as twos complement words, unchanged.
    assign dac_a_o = cv_q[0];
    assign dac_b_o = cv_q[1];
endmodule
`default_nettype wire

// file: bench/ddbl_host_monitor.sv
// Checker of the host controller's bus and pin timing.
`timescale 1ns/100ps
`default_nettype none
module ddbl_host_chk (
    input wire logic clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Bus strobe.
    input wire logic wb_ack_o, // Bus acknowledge.
    input wire logic [7:0] data_o, // Data pins.
    input wire logic low_byte_latch_en_n_o, // Low byte enable.
    input wire logic high_byte_latch_en_n_o, // High byte enable.
    input wire logic converter_latch_en_n_o, // Converter enable.
    input wire logic wr_a_n_o, // Strobe A.
    input wire logic cs_a_n_o, // Select A.
    input wire logic wr_b_n_o, // Strobe B.
    input wire logic cs_b_n_o, // Select B.
    input wire logic zero_all_n_o, // Clear line.
    input wire logic busy_o // Busy.
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // All checks run on the clock and rest while reset is high.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Late ack.");
    a_strobe_width: assert property ($fell(wr_a_n_o) |->
        (!wr_a_n_o)[*8] ##1 (!wr_a_n_o)[*5] ##1 wr_a_n_o)
        else $error("Width.");
    a_strobe_width_b: assert property ($fell(wr_b_n_o) |->
        (!wr_b_n_o)[*8] ##1 (!wr_b_n_o)[*5] ##1 wr_b_n_o)
        else $error("Width on B.");
    a_gap_a: assert property (
        $rose(wr_a_n_o) |-> wr_a_n_o[*8]) else $error("Short gap on A.");
    a_gap_b: assert property (
        $rose(wr_b_n_o) |-> wr_b_n_o[*8]) else $error("Short gap on B.");
    a_one_select: assert property (
        cs_a_n_o || cs_b_n_o) else $error("Both selects low.");
    a_strobe_cs: assert property (
        (wr_a_n_o || !cs_a_n_o) && (wr_b_n_o || !cs_b_n_o))
        else $error("No cs.");
    a_steady_pins: assert property ((!wr_a_n_o || !wr_b_n_o) |->
        $stable({data_o, low_byte_latch_en_n_o, high_byte_latch_en_n_o,
        converter_latch_en_n_o, cs_a_n_o, cs_b_n_o})) else $error("Moved.");
    a_serial_conv: assert property (
        !low_byte_latch_en_n_o && !high_byte_latch_en_n_o
        |-> converter_latch_en_n_o) else $error("Serial with converter.");
    a_conv_alone: assert property (!converter_latch_en_n_o |->
        low_byte_latch_en_n_o && high_byte_latch_en_n_o) else $error("Flow.");
    a_clear_pulse: assert property ($fell(zero_all_n_o) |->
        (cs_a_n_o && cs_b_n_o && !zero_all_n_o)[*8] ##1 (!zero_all_n_o)[*5]
        ##1 zero_all_n_o) else $error("Bad clear pulse.");
    a_idle_pins: assert property (!busy_o |-> wr_a_n_o && wr_b_n_o &&
        cs_a_n_o && cs_b_n_o && zero_all_n_o && data_o == 8'h00)
        else $error("Pins active while idle.");
    c_clear: cover property ($fell(zero_all_n_o));
    c_serial: cover property (!wr_a_n_o && !low_byte_latch_en_n_o);
    c_conv_b: cover property (!wr_b_n_o && !converter_latch_en_n_o);
endmodule
bind ddbl_host ddbl_host_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .data_o(data_o), .low_byte_latch_en_n_o(low_byte_latch_en_n_o),
    .high_byte_latch_en_n_o(high_byte_latch_en_n_o),
    .converter_latch_en_n_o(converter_latch_en_n_o), .wr_a_n_o(wr_a_n_o),
    .cs_a_n_o(cs_a_n_o), .wr_b_n_o(wr_b_n_o), .cs_b_n_o(cs_b_n_o),
    .zero_all_n_o(zero_all_n_o), .busy_o(busy_o));
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the dual converter host controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_i = 0;
    logic rst_i = 1;
    logic wb_cyc_i = 0;
    logic wb_stb_i = 0;
    logic wb_we_i = 0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, busy_o, lo_n, hi_n, cv_n, zero_n;
    wire [7:0] data;
    wire [1:0] wr_n, cs_n;
    wire [15:0] dac_a, dac_b;
    logic [31:0] rd_q [$];
    logic [31:0] dq [$];
    logic busy_q = 0;
    int fails = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    logic [15:0] wa, wb, ea, eb;
    logic [4:0] cmd;
    logic [15:0] codes [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0000};
    logic [4:0] cmds [4] = '{5'h01, 5'h0a, 5'h07, 5'h0b};
    ddbl_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .data_o(data), .low_byte_latch_en_n_o(lo_n),
        .high_byte_latch_en_n_o(hi_n), .converter_latch_en_n_o(cv_n),
        .wr_a_n_o(wr_n[0]), .cs_a_n_o(cs_n[0]), .wr_b_n_o(wr_n[1]),
        .cs_b_n_o(cs_n[1]), .zero_all_n_o(zero_n), .busy_o(busy_o));
    ddbl_dev_model i_dev (.clk_i(clk_i), .data_i(data), .lo_n_i(lo_n),
        .hi_n_i(hi_n), .cv_n_i(cv_n), .wr_n_i(wr_n), .cs_n_i(cs_n),
        .zero_all_n_i(zero_n), .dac_a_o(dac_a), .dac_b_o(dac_b));
    // Compares one read word with its note and counts the outcome.
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] a);
        n_compared++;
        if (a !== e) begin
            fails++;
            $display("MISMATCH at %0t: read %h, expected %h", $time, a, e);
        end
    endtask
    // Compares both converter codes with their note.
    task automatic chk_dac(input logic [31:0] e, input logic [31:0] a);
        n_compared++;
        if (a !== e) begin
            fails++;
            $display("MISMATCH at %0t: codes %h, expected %h", $time, a, e);
        end
    endtask
    // One classic bus cycle, held until ack is seen.
    task automatic bus(input logic we, input logic [3:0] adr,
                       input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] adr, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, adr, 32'h0);
    endtask
    // Starts a sequence and notes the converter codes it must leave.
    task automatic run(input logic [4:0] c, input logic [31:0] e);
        dq.push_back(e);
        bus(1'b1, 4'h0, {27'h0, c});
        repeat (2) @(posedge clk_i);
    endtask
    task automatic idle;
        while (busy_o !== 1'b0) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic end_sim;
        // A note that never met its result is a mismatch as well.
        if (rd_q.size() != 0 || dq.size() != 0) fails++;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, watcher and sequence
    // ------------------------------------------------------------
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Takes the oldest note whenever read data or an idle edge appears.
    always @(posedge clk_i) begin
        busy_q <= busy_o;
        cyc_cnt <= cyc_cnt + 1;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk_rd(rd_q.pop_front(), wb_dat_o);
        if (busy_q === 1'b1 && busy_o === 1'b0)
            chk_dac(dq.pop_front(), {dac_a, dac_b});
        if (cyc_cnt == 20000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(22));
        codes[3] = 16'($urandom);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 16; a += 2) rd(a[3:0], 32'h0);
        $display("test 1 done");
        run(5'h10, 32'h0);
        idle();
        $display("test 2 done");
        ea = 16'h0000;
        eb = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            wa = codes[i];
            wb = ~codes[i];
            bus(1'b1, 4'h4, {16'h0, wa});
            bus(1'b1, 4'h8, {16'h0, wb});
            rd(4'h4, {16'h0, wa});
            cmd = cmds[i];
            if (cmd[0]) ea = wa;
            if (cmd[1]) eb = wb;
            run(cmd, {ea, eb});
            if (i == 3) rd(4'hc, 32'h1);
            if (i == 3) bus(1'b1, 4'h0, 32'h10);
            idle();
            if (i == 3) begin
                rd(4'hc, 32'h2);
                bus(1'b1, 4'hc, 32'h2);
                rd(4'hc, 32'h0);
            end
            $display("test %0d done", i + 3);
        end
        bus(1'b1, 4'h0, 32'h08);
        rd(4'hc, 32'h0);
        rd(4'h0, 32'h08);
        $display("test 7 done");
        repeat (2) @(posedge clk_i);
        end_sim();
    end
endmodule
`default_nettype wire

// file: hw/ddbl_defines.vh
// Constants for the dual converter byte-latch host controller.
`ifndef DDBL_DEFINES_VH
`define DDBL_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define DDBL_ADR_CMD 4'h0
`define DDBL_ADR_WORD_A 4'h4
`define DDBL_ADR_WORD_B 4'h8
`define DDBL_ADR_STATUS 4'hc

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define DDBL_CMD_CHAN_A 0
`define DDBL_CMD_CHAN_B 1
`define DDBL_CMD_SERIAL 2
`define DDBL_CMD_LOW_FIRST 3
`define DDBL_CMD_CLEAR 4
`define DDBL_CMD_W 5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define DDBL_STA_BUSY 0
`define DDBL_STA_REFUSED 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DDBL_RST_CMD 5'h00
`define DDBL_RST_WORD 16'h0000

// ----------------------------------------------------------------
// Timing: each pin phase lasts 13 cycles (52 ns), a whole strobe step 156 ns
// ----------------------------------------------------------------
`define DDBL_CLK_PERIOD_NS 4
`define DDBL_T_PHASE_NS 50
`define DDBL_PHASE_CYC \
    ((`DDBL_T_PHASE_NS + `DDBL_CLK_PERIOD_NS - 1) / `DDBL_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Step counts
// ----------------------------------------------------------------
`define DDBL_PAR_LAST_STEP 5'h02
`define DDBL_SER_LAST_STEP 5'h10

`endif

// file: hw/ddbl_host.v
// Host controller driving a dual 16-bit converter's byte-latch pins.
//
// Function
// - Each word goes as two bytes, either order.
// - Serial: one bit per strobe, MSB first.
// - Latch toggling stays below 10 MHz.
// - At least 20 ns between successive strobes.
// - Serial bits clocked below 10 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "ddbl_defines.vh"

module ddbl_host (
    input wire clk_i,                      // System clock, 250 MHz.
    input wire rst_i,                      // Synchronous reset, high.
    input wire wb_cyc_i,                   // Wishbone cycle.
    input wire wb_stb_i,                   // Wishbone strobe.
    input wire wb_we_i,                    // Wishbone write enable.
    input wire [3:0] wb_adr_i,             // Wishbone byte address.
    input wire [3:0] wb_sel_i,             // Wishbone byte lanes.
    input wire [31:0] wb_dat_i,            // Wishbone write data.
    output reg [31:0] wb_dat_o,            // Wishbone read data.
    output reg wb_ack_o,                   // Wishbone acknowledge.
    output reg [7:0] data_o,               // Shared byte-wide data pins.
    output reg low_byte_latch_en_n_o,      // Low byte latch enable.
    output reg high_byte_latch_en_n_o,     // High byte latch enable.
    output reg converter_latch_en_n_o,     // Converter latch enable.
    output reg wr_a_n_o,                   // Channel A write strobe.
    output reg cs_a_n_o,                   // Channel A chip select.
    output reg wr_b_n_o,                   // Channel B write strobe.
    output reg cs_b_n_o,                   // Channel B chip select.
    output reg zero_all_n_o,               // Clear line.
    output reg busy_o                      // Sequence in progress.
);

    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SETUP = 4'h2;
    localparam [3:0] ST_STROBE = 4'h4;
    localparam [3:0] ST_HOLD = 4'h8;
    localparam integer PHASE_LAST_I = `DDBL_PHASE_CYC - 1;
    localparam [4:0] PHASE_LAST = PHASE_LAST_I[4:0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg [`DDBL_CMD_W-1:0] cmd_reg;
    reg [15:0] word_a_reg;
    reg [15:0] word_b_reg;
    reg refused_reg;
    reg [3:0] state_reg;
    reg [4:0] tmr_reg;
    reg [4:0] step_reg;
    reg chan_reg;
    reg pend_b_reg;
    reg ser_reg;
    reg lofirst_reg;
    reg clr_reg;

    // Bus request decode; writes take effect on the acknowledged edge.
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_take = req & wb_ack_o & wb_we_i;
    wire cmd_wr = wr_take & (wb_adr_i == `DDBL_ADR_CMD) & wb_sel_i[0];
    wire sta_wr = wr_take & (wb_adr_i == `DDBL_ADR_STATUS) & wb_sel_i[0];
    wire [1:0] cmd_ch = {wb_dat_i[`DDBL_CMD_CHAN_B],
                         wb_dat_i[`DDBL_CMD_CHAN_A]};
    wire cmd_clr = wb_dat_i[`DDBL_CMD_CLEAR];
    wire cmd_go = cmd_clr | (|cmd_ch);
    wire start = cmd_wr & cmd_go & ~busy_o;
    wire refuse = cmd_wr & cmd_go & busy_o;

    // Pin pattern of the current step.
    wire [15:0] word_sel = chan_reg ? word_b_reg : word_a_reg;
    wire [15:0] ser_sh = word_sel << step_reg;
    wire [4:0] last_step = ser_reg ? `DDBL_SER_LAST_STEP
                                   : `DDBL_PAR_LAST_STEP;
    wire is_xfer = (step_reg == last_step);
    wire par_lo = (step_reg == 5'h00) ? lofirst_reg : ~lofirst_reg;
    reg [7:0] pat_data;
    reg pat_lo_n;
    reg pat_hi_n;
    reg pat_cv_n;

    // ------------------------------------------------------------
    // Step decode
    // ------------------------------------------------------------
    // Works out enables and data for the step being driven.
    always @* begin
        pat_data = 8'h00;
        pat_lo_n = 1'b1;
        pat_hi_n = 1'b1;
        pat_cv_n = 1'b1;
        if (is_xfer) begin
            pat_cv_n = 1'b0;
        end else if (ser_reg) begin
            pat_lo_n = 1'b0;
            pat_hi_n = 1'b0;
            pat_data = {7'h00, ser_sh[15]};
        end else if (par_lo) begin
            pat_lo_n = 1'b0;
            pat_data = word_sel[7:0];
        end else begin
            pat_hi_n = 1'b0;
            pat_data = word_sel[15:8];
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // Answers every request one cycle later; unmapped reads give zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o) begin
                case (wb_adr_i)
                    `DDBL_ADR_CMD: wb_dat_o <= {27'h0, cmd_reg};
                    `DDBL_ADR_WORD_A: wb_dat_o <= {16'h0, word_a_reg};
                    `DDBL_ADR_WORD_B: wb_dat_o <= {16'h0, word_b_reg};
                    `DDBL_ADR_STATUS: wb_dat_o <= {30'h0, refused_reg,
                                                   busy_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software registers; twos complement words are kept as written.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= `DDBL_RST_CMD;
            word_a_reg <= `DDBL_RST_WORD;
            word_b_reg <= `DDBL_RST_WORD;
            refused_reg <= 1'b0;
        end else begin
            if (cmd_wr) begin
                cmd_reg <= wb_dat_i[`DDBL_CMD_W-1:0];
            end
            if (wr_take & (wb_adr_i == `DDBL_ADR_WORD_A)) begin
                if (wb_sel_i[0]) word_a_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) word_a_reg[15:8] <= wb_dat_i[15:8];
            end
            if (wr_take & (wb_adr_i == `DDBL_ADR_WORD_B)) begin
                if (wb_sel_i[0]) word_b_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) word_b_reg[15:8] <= wb_dat_i[15:8];
            end
            // A new refusal wins over a clear in the same cycle.
            if (refuse) begin
                refused_reg <= 1'b1;
            end else if (sta_wr & wb_dat_i[`DDBL_STA_REFUSED]) begin
                refused_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------
    // Each step is setup, strobe low and hold, 13 cycles (52 ns) apiece.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            tmr_reg <= 5'h00;
            step_reg <= 5'h00;
            chan_reg <= 1'b0;
            pend_b_reg <= 1'b0;
            ser_reg <= 1'b0;
            lofirst_reg <= 1'b0;
            clr_reg <= 1'b0;
            busy_o <= 1'b0;
            data_o <= 8'h00;
            low_byte_latch_en_n_o <= 1'b1;
            high_byte_latch_en_n_o <= 1'b1;
            converter_latch_en_n_o <= 1'b1;
            wr_a_n_o <= 1'b1;
            cs_a_n_o <= 1'b1;
            wr_b_n_o <= 1'b1;
            cs_b_n_o <= 1'b1;
            zero_all_n_o <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        busy_o <= 1'b1;
                        clr_reg <= cmd_clr;
                        ser_reg <= wb_dat_i[`DDBL_CMD_SERIAL];
                        lofirst_reg <= wb_dat_i[`DDBL_CMD_LOW_FIRST];
                        chan_reg <= ~cmd_ch[0];
                        pend_b_reg <= cmd_ch[0] & cmd_ch[1];
                        step_reg <= 5'h00;
                        tmr_reg <= 5'h00;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (~clr_reg) begin
                        data_o <= pat_data;
                        low_byte_latch_en_n_o <= pat_lo_n;
                        high_byte_latch_en_n_o <= pat_hi_n;
                        converter_latch_en_n_o <= pat_cv_n;
                        cs_a_n_o <= chan_reg;
                        cs_b_n_o <= ~chan_reg;
                    end
                    tmr_reg <= tmr_reg + 5'h01;
                    if (tmr_reg == PHASE_LAST) begin
                        tmr_reg <= 5'h00;
                        state_reg <= ST_STROBE;
                        if (clr_reg) begin
                            zero_all_n_o <= 1'b0;
                        end else begin
                            wr_a_n_o <= chan_reg;
                            wr_b_n_o <= ~chan_reg;
                        end
                    end
                end
                ST_STROBE: begin
                    tmr_reg <= tmr_reg + 5'h01;
                    if (tmr_reg == PHASE_LAST) begin
                        tmr_reg <= 5'h00;
                        state_reg <= ST_HOLD;
                        zero_all_n_o <= 1'b1;
                        wr_a_n_o <= 1'b1;
                        wr_b_n_o <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    // Strobe high this long keeps the rate legal.
                    tmr_reg <= tmr_reg + 5'h01;
                    if (tmr_reg == PHASE_LAST) begin
                        tmr_reg <= 5'h00;
                        if (~clr_reg & ~is_xfer) begin
                            step_reg <= step_reg + 5'h01;
                            state_reg <= ST_SETUP;
                        end else if (~clr_reg & pend_b_reg) begin
                            pend_b_reg <= 1'b0;
                            chan_reg <= 1'b1;
                            step_reg <= 5'h00;
                            cs_a_n_o <= 1'b1;
                            state_reg <= ST_SETUP;
                        end else begin
                            busy_o <= 1'b0;
                            data_o <= 8'h00;
                            low_byte_latch_en_n_o <= 1'b1;
                            high_byte_latch_en_n_o <= 1'b1;
                            converter_latch_en_n_o <= 1'b1;
                            cs_a_n_o <= 1'b1;
                            cs_b_n_o <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire
